// ==== include/asc_pkg.sv ====
// constants for the serial controller command and status block
// assumes an axi4-lite master with 32-bit data and 8-bit byte addresses
package asc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte addresses
  localparam logic [7:0] OFF_MODEM_STATUS = 8'h00;
  localparam logic [7:0] OFF_DEVICE_CMD = 8'h04;
  localparam logic [7:0] OFF_TX_CMD = 8'h08;
  localparam logic [7:0] OFF_RX_CMD = 8'h0C;
  localparam logic [7:0] OFF_TIMER_CMD = 8'h10;
  localparam logic [7:0] OFF_MODEM_CTRL = 8'h14;
  localparam logic [7:0] OFF_TX_BYTE = 8'h18;
  localparam logic [7:0] OFF_TX_FLAGS = 8'h1C;
  localparam logic [7:0] OFF_RX_BYTE = 8'h20;
  localparam logic [7:0] OFF_TIMER_STATUS = 8'h24;
  localparam logic [7:0] OFF_PIN_MODE = 8'h28;
  localparam logic [7:0] OFF_IF_MODE = 8'h2C;
  localparam logic [7:0] OFF_BLOCK_STATUS = 8'h30;
  localparam logic [7:0] OFF_RX_FLAGS = 8'h34;
  // modem status fields
  localparam int MS_CTS_CHG = 0;
  localparam int MS_DSR_CHG = 1;
  localparam int MS_RING_FELL = 2;
  localparam int MS_DCD_CHG = 3;
  localparam int MS_CTS_INV = 4;
  localparam int MS_DSR_INV = 5;
  localparam int MS_RING_INV = 6;
  localparam int MS_DCD_INV = 7;
  // device command fields
  localparam int DC_SOFT_RESET = 0;
  localparam int DC_IRQ_ACK = 1;
  localparam int DC_CLEAR_STATUS = 2;
  localparam int DC_POWER_DOWN = 3;
  // transmit command fields
  localparam int TC_ENGINE_FLUSH = 0;
  localparam int TC_QUEUE_FLUSH = 1;
  localparam int TC_ENABLE = 2;
  localparam int TC_DISABLE = 3;
  // receive command fields
  localparam int RC_ENABLE = 0;
  localparam int RC_DISABLE = 1;
  localparam int RC_ENGINE_FLUSH = 2;
  localparam int RC_QUEUE_FLUSH = 3;
  localparam int RC_LOCK = 4;
  localparam int RC_UNLOCK = 5;
  // timer command fields
  localparam int TM_A_START = 0;
  localparam int TM_B_START = 1;
  localparam int TM_A_GATE = 2;
  localparam int TM_B_GATE = 3;
  // timer status fields
  localparam int TS_A_EXPIRED = 0;
  localparam int TS_B_EXPIRED = 1;
  localparam int TS_A_GATE = 2;
  localparam int TS_B_GATE = 3;
  // modem control fields
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_GP_OUTPUT_ONE = 2;
  localparam int MC_GP_OUTPUT_TWO = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_GP_OUTPUT_ZERO = 5;
  // pin mode fields: 1 = modem input / general output
  localparam int PM_DCD_IN = 0;
  localparam int PM_RI_IN = 1;
  localparam int PM_DSR_IN = 2;
  localparam int PM_GP_OUTPUT_ZERO_GP = 3;
  localparam int PM_GP_OUTPUT_ONE_GP = 4;
  localparam int PM_GP_OUTPUT_TWO_GP = 5;
  localparam int PM_RTS_GP = 6;
  localparam int PM_DTR_GP = 7;
  // transmit flags fields
  localparam int TF_NINTH = 0;
  localparam int TF_PARITY = 1;
  localparam int TF_MARKER = 2;
  // reset values
  localparam logic [7:0] PIN_MODE_RST = 8'hFF;
  localparam logic [7:0] IF_MODE_RST = 8'h00;
  localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
  localparam logic [7:0] TX_FLAGS_RST = 8'h00;
  // timing counts in core clocks
  localparam logic [2:0] SOFT_RESET_CYCLES = 3'h4;
  localparam logic [1:0] ACK_HOLD_CYCLES = 2'h2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESPOND = 1'b1
  } asc_wr_state_t;
endpackage

// ==== src/asc_cmd_status.sv ====
// command, modem status/control and data register logic of the controller
// assumes engines, fifos, timers and interrupt priority logic sit outside;
// all non-bus inputs are synchronous to CORE_CLK
// Behaviour
// - modem deltas latch, raise modem irq, read-clear
// - show inverted modem input levels when inputs
// - ring sets on fall; others any change
// - gate state mirrors written gate, no irq
// - terminal count sets expired, raises timer irq
// - command registers write-only, self clearing
// - soft reset: four clocks, like hardware reset
// - irq acknowledge holds interrupt low two clocks
// - status clear; power-down command enters power down
// - tx engine flush enables; tx queue flush empties
// - tx enable; disable finishes current character
// - rx enable and rx disable commands
// - rx engine flush enables, unlocks; queue flush
// - lock discards new characters; unlock restores
// - gates persist; no effect on baud timers
// - start commands trigger timers, expiry sets status
// - control bits drive inverted general-purpose pins
// - loopback bit enables loopback, variant from mode
// - tx byte write pushes byte plus flags
// - flags carry marker, parity, ninth bit
// - rx byte holds oldest; read loads next
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
module asc_cmd_status (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [asc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [asc_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [asc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [asc_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic DCD_N,
  input wire logic RI_N,
  input wire logic DSR_N,
  input wire logic CTS_N,
  output logic DTR_N,
  output logic DTR_OE,
  output logic RTS_N,
  output logic RTS_OE,
  output logic GP_OUTPUT_ZERO_N,
  output logic GP_OUTPUT_ZERO_OE,
  output logic GP_OUTPUT_ONE_N,
  output logic GP_OUTPUT_ONE_OE,
  output logic GP_OUTPUT_TWO_N,
  output logic GP_OUTPUT_TWO_OE,
  output logic LOOPBACK_EN,
  output logic [1:0] LOOPBACK_KIND,
  input wire logic IRQ_PENDING,
  output logic INT_OUT,
  output logic MODEM_IRQ_REQ,
  output logic TIMER_IRQ_REQ,
  output logic DEVICE_RESET,
  output logic POWER_DOWN,
  output logic RX_STATUS_CLEAR,
  output logic TX_ENABLE,
  output logic TX_ENGINE_FLUSH,
  output logic TX_QUEUE_FLUSH,
  output logic RX_ENABLE,
  output logic RX_ENGINE_FLUSH,
  output logic RX_QUEUE_FLUSH,
  output logic RX_QUEUE_WRITE_EN,
  input wire logic TIMER_A_IS_BAUD,
  input wire logic TIMER_B_IS_BAUD,
  output logic TIMER_A_GATE,
  output logic TIMER_B_GATE,
  output logic TIMER_A_START,
  output logic TIMER_B_START,
  input wire logic TIMER_A_TC,
  input wire logic TIMER_B_TC,
  input wire logic TXQ_READY,
  output logic TXQ_PUSH,
  output logic [7:0] TXQ_DATA,
  output logic [2:0] TXQ_FLAGS,
  input wire logic RXQ_VALID,
  input wire logic [7:0] RXQ_DATA,
  input wire logic [7:0] RXQ_FLAGS,
  output logic RXQ_POP
);
  import asc_pkg::*;

  // bus state
  asc_wr_state_t wr_state_reg;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic [1:0] bresp_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rdata_reg;
  // block state
  logic [2:0] soft_reset_cmd_cnt_reg;
  logic [1:0] ack_cnt_reg;
  logic [7:0] modem_ctrl_reg;
  logic [7:0] pin_mode_reg;
  logic [7:0] if_mode_reg;
  logic [7:0] tx_flags_reg;
  logic [3:0] modem_chg_reg;
  logic [3:0] modem_chg_next;
  logic dcd_prev_reg;
  logic ri_prev_reg;
  logic dsr_prev_reg;
  logic cts_prev_reg;
  logic [1:0] expired_reg;
  logic [1:0] expired_next;
  logic [1:0] gate_reg;
  logic tx_en_reg;
  logic rx_en_reg;
  logic rx_locked_reg;
  logic pdown_reg;
  logic rx_full_reg;
  logic [7:0] rx_data_reg;
  logic [7:0] rx_flags_reg;

  // software reset counts down; bus handshakes only see RST_B
  wire soft_reset_cmd_active = (soft_reset_cmd_cnt_reg != 3'h0);
  wire blk_rst = !RST_B || soft_reset_cmd_active;

  // write decode
  wire aw_have = !S_AXI_AWREADY;
  wire w_have = !S_AXI_WREADY;
  wire wr_to_txb = (aw_addr_reg == OFF_TX_BYTE);
  // a tx byte write waits until the queue can take it
  wire wr_fire = (wr_state_reg == WR_COLLECT) && aw_have && w_have &&
                 !(wr_to_txb && w_lane_reg && !TXQ_READY);
  wire wr_ok = wr_fire && w_lane_reg;
  wire sel_dev = wr_ok && (aw_addr_reg == OFF_DEVICE_CMD);
  wire sel_tx = wr_ok && (aw_addr_reg == OFF_TX_CMD);
  wire sel_rx = wr_ok && (aw_addr_reg == OFF_RX_CMD);
  wire sel_tm = wr_ok && (aw_addr_reg == OFF_TIMER_CMD);
  wire sel_mc = wr_ok && (aw_addr_reg == OFF_MODEM_CTRL);
  wire sel_txb = wr_ok && wr_to_txb;
  wire sel_txf = wr_ok && (aw_addr_reg == OFF_TX_FLAGS);
  wire sel_pm = wr_ok && (aw_addr_reg == OFF_PIN_MODE);
  wire sel_im = wr_ok && (aw_addr_reg == OFF_IF_MODE);
  wire wr_mapped = (aw_addr_reg == OFF_MODEM_STATUS) ||
                   (aw_addr_reg == OFF_DEVICE_CMD) ||
                   (aw_addr_reg == OFF_TX_CMD) ||
                   (aw_addr_reg == OFF_RX_CMD) ||
                   (aw_addr_reg == OFF_TIMER_CMD) ||
                   (aw_addr_reg == OFF_MODEM_CTRL) ||
                   (aw_addr_reg == OFF_TX_BYTE) ||
                   (aw_addr_reg == OFF_TX_FLAGS) ||
                   (aw_addr_reg == OFF_RX_BYTE) ||
                   (aw_addr_reg == OFF_TIMER_STATUS) ||
                   (aw_addr_reg == OFF_PIN_MODE) ||
                   (aw_addr_reg == OFF_IF_MODE) ||
                   (aw_addr_reg == OFF_BLOCK_STATUS) ||
                   (aw_addr_reg == OFF_RX_FLAGS);

  // command bits act only in the write cycle and are never stored
  wire cmd_soft_reset_cmd = sel_dev && w_data_reg[DC_SOFT_RESET];
  wire cmd_ack = sel_dev && w_data_reg[DC_IRQ_ACK];
  wire cmd_stc = sel_dev && w_data_reg[DC_CLEAR_STATUS];
  wire cmd_pdm = sel_dev && w_data_reg[DC_POWER_DOWN];
  wire cmd_tx_flush = sel_tx && w_data_reg[TC_ENGINE_FLUSH];
  wire cmd_txq_flush = sel_tx && w_data_reg[TC_QUEUE_FLUSH];
  wire cmd_tx_en = sel_tx && w_data_reg[TC_ENABLE];
  wire cmd_tx_dis = sel_tx && w_data_reg[TC_DISABLE];
  wire cmd_rx_en = sel_rx && w_data_reg[RC_ENABLE];
  wire cmd_rx_dis = sel_rx && w_data_reg[RC_DISABLE];
  wire cmd_rx_flush = sel_rx && w_data_reg[RC_ENGINE_FLUSH];
  wire cmd_rxq_flush = sel_rx && w_data_reg[RC_QUEUE_FLUSH];
  wire cmd_lock = sel_rx && w_data_reg[RC_LOCK];
  wire cmd_unlock = sel_rx && w_data_reg[RC_UNLOCK];
  // baud-rate timers ignore the timer command register
  wire cmd_sta = sel_tm && w_data_reg[TM_A_START] && !TIMER_A_IS_BAUD;
  wire cmd_stb = sel_tm && w_data_reg[TM_B_START] && !TIMER_B_IS_BAUD;

  // read decode
  wire rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  wire rd_ms = rd_fire && (S_AXI_ARADDR == OFF_MODEM_STATUS);
  wire rd_rxb = rd_fire && (S_AXI_ARADDR == OFF_RX_BYTE);

  // modem inputs: levels shown inverted only where the pin is an input
  wire dcd_in = pin_mode_reg[PM_DCD_IN];
  wire ri_in = pin_mode_reg[PM_RI_IN];
  wire dsr_in = pin_mode_reg[PM_DSR_IN];
  wire [3:0] modem_lvl = {dcd_in && !DCD_N, ri_in && !RI_N,
                          dsr_in && !DSR_N, !CTS_N};
  wire [3:0] modem_evt = {dcd_in && (DCD_N != dcd_prev_reg),
                          ri_in && ri_prev_reg && !RI_N,
                          dsr_in && (DSR_N != dsr_prev_reg),
                          CTS_N != cts_prev_reg};
  wire [7:0] modem_status = {modem_lvl, modem_chg_reg[3], modem_chg_reg[2],
                             modem_chg_reg[1], modem_chg_reg[0]};
  wire [7:0] timer_status = {4'h0, gate_reg, expired_reg};
  wire [7:0] block_status = {2'h0, pdown_reg, rx_locked_reg, rx_en_reg,
                             tx_en_reg, TIMER_IRQ_REQ, MODEM_IRQ_REQ};
  wire [7:0] rd_mux =
    (S_AXI_ARADDR == OFF_MODEM_STATUS) ? modem_status :
    (S_AXI_ARADDR == OFF_MODEM_CTRL) ? modem_ctrl_reg :
    (S_AXI_ARADDR == OFF_TX_FLAGS) ? tx_flags_reg :
    (S_AXI_ARADDR == OFF_RX_BYTE) ? rx_data_reg :
    (S_AXI_ARADDR == OFF_TIMER_STATUS) ? timer_status :
    (S_AXI_ARADDR == OFF_PIN_MODE) ? pin_mode_reg :
    (S_AXI_ARADDR == OFF_IF_MODE) ? if_mode_reg :
    (S_AXI_ARADDR == OFF_BLOCK_STATUS) ? block_status :
    (S_AXI_ARADDR == OFF_RX_FLAGS) ? rx_flags_reg : 8'h00;
  // write-only command and data registers read as zero
  wire rd_mapped = (S_AXI_ARADDR <= OFF_RX_FLAGS) &&
                   (S_AXI_ARADDR[1:0] == 2'h0);

  // set wins over read-clear and status clear
  assign modem_chg_next = (modem_chg_reg & {4{!(rd_ms || cmd_stc)}}) |
                          modem_evt;
  assign expired_next = (expired_reg & {2{!cmd_stc}}) |
                        {TIMER_B_TC, TIMER_A_TC};

  // write channel
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      wr_state_reg <= WR_COLLECT;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        w_data_reg <= S_AXI_WDATA[7:0];
        w_lane_reg <= S_AXI_WSTRB[0];
      end
      case (wr_state_reg)
        WR_COLLECT: begin
          if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            wr_state_reg <= WR_RESPOND;
          end
        end
        WR_RESPOND: begin
          if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            wr_state_reg <= WR_COLLECT;
          end
        end
        default: wr_state_reg <= WR_COLLECT;
      endcase
    end
  end
  assign S_AXI_BRESP = bresp_reg;

  // read channel
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      rdata_reg <= 8'h00;
      rresp_reg <= RESP_OKAY;
    end else if (rd_fire) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end
  assign S_AXI_RDATA = {24'h000000, rdata_reg};
  assign S_AXI_RRESP = rresp_reg;

  // software reset sequencer, held for a fixed count of clocks
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      soft_reset_cmd_cnt_reg <= 3'h0;
      DEVICE_RESET <= 1'b0;
    end else begin
      if (cmd_soft_reset_cmd) begin
        soft_reset_cmd_cnt_reg <= SOFT_RESET_CYCLES;
      end else if (soft_reset_cmd_active) begin
        soft_reset_cmd_cnt_reg <= soft_reset_cmd_cnt_reg - 3'h1;
      end
      DEVICE_RESET <= cmd_soft_reset_cmd || (soft_reset_cmd_cnt_reg > 3'h1);
    end
  end

  // interrupt acknowledge gating of the pending request
  always_ff @(posedge CORE_CLK) begin
    if (blk_rst) begin
      ack_cnt_reg <= 2'h0;
      INT_OUT <= 1'b0;
    end else begin
      if (cmd_ack) begin
        ack_cnt_reg <= ACK_HOLD_CYCLES - 2'h1;
      end else if (ack_cnt_reg != 2'h0) begin
        ack_cnt_reg <= ack_cnt_reg - 2'h1;
      end
      INT_OUT <= IRQ_PENDING && !cmd_ack && (ack_cnt_reg == 2'h0);
    end
  end

  // modem status and timer status
  always_ff @(posedge CORE_CLK) begin
    if (blk_rst) begin
      modem_chg_reg <= 4'h0;
      dcd_prev_reg <= 1'b1;
      ri_prev_reg <= 1'b1;
      dsr_prev_reg <= 1'b1;
      cts_prev_reg <= 1'b1;
      MODEM_IRQ_REQ <= 1'b0;
      expired_reg <= 2'h0;
      TIMER_IRQ_REQ <= 1'b0;
      RX_STATUS_CLEAR <= 1'b0;
    end else begin
      dcd_prev_reg <= DCD_N;
      ri_prev_reg <= RI_N;
      dsr_prev_reg <= DSR_N;
      cts_prev_reg <= CTS_N;
      modem_chg_reg <= modem_chg_next;
      MODEM_IRQ_REQ <= |modem_chg_next;
      expired_reg <= expired_next;
      TIMER_IRQ_REQ <= |expired_next;
      RX_STATUS_CLEAR <= cmd_stc;
    end
  end

  // control levels and command pulses
  always_ff @(posedge CORE_CLK) begin
    if (blk_rst) begin
      pdown_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      rx_locked_reg <= 1'b0;
      RX_QUEUE_WRITE_EN <= 1'b1;
      gate_reg <= 2'h0;
      TX_ENGINE_FLUSH <= 1'b0;
      TX_QUEUE_FLUSH <= 1'b0;
      RX_ENGINE_FLUSH <= 1'b0;
      RX_QUEUE_FLUSH <= 1'b0;
      TIMER_A_START <= 1'b0;
      TIMER_B_START <= 1'b0;
    end else begin
      if (cmd_pdm) begin
        pdown_reg <= 1'b1;
      end
      // the engine finishes its current character once enable drops
      if (cmd_tx_dis) begin
        tx_en_reg <= 1'b0;
      end else if (cmd_tx_en || cmd_tx_flush) begin
        tx_en_reg <= 1'b1;
      end
      if (cmd_rx_dis) begin
        rx_en_reg <= 1'b0;
      end else if (cmd_rx_en || cmd_rx_flush) begin
        rx_en_reg <= 1'b1;
      end
      if (cmd_unlock || cmd_rx_flush) begin
        rx_locked_reg <= 1'b0;
        RX_QUEUE_WRITE_EN <= 1'b1;
      end else if (cmd_lock) begin
        rx_locked_reg <= 1'b1;
        RX_QUEUE_WRITE_EN <= 1'b0;
      end
      if (sel_tm) begin
        gate_reg <= {w_data_reg[TM_B_GATE], w_data_reg[TM_A_GATE]};
      end
      TX_ENGINE_FLUSH <= cmd_tx_flush;
      TX_QUEUE_FLUSH <= cmd_txq_flush;
      RX_ENGINE_FLUSH <= cmd_rx_flush;
      RX_QUEUE_FLUSH <= cmd_rxq_flush;
      TIMER_A_START <= cmd_sta;
      TIMER_B_START <= cmd_stb;
    end
  end
  assign POWER_DOWN = pdown_reg;
  assign TX_ENABLE = tx_en_reg;
  assign RX_ENABLE = rx_en_reg;

  // a baud-rate timer runs regardless of the software gate
  always_ff @(posedge CORE_CLK) begin
    if (blk_rst) begin
      TIMER_A_GATE <= 1'b0;
      TIMER_B_GATE <= 1'b0;
    end else begin
      TIMER_A_GATE <= gate_reg[0] || TIMER_A_IS_BAUD;
      TIMER_B_GATE <= gate_reg[1] || TIMER_B_IS_BAUD;
    end
  end

  // software-written configuration
  always_ff @(posedge CORE_CLK) begin
    if (blk_rst) begin
      modem_ctrl_reg <= MODEM_CTRL_RST;
      pin_mode_reg <= PIN_MODE_RST;
      if_mode_reg <= IF_MODE_RST;
      tx_flags_reg <= TX_FLAGS_RST;
    end else begin
      if (sel_mc) begin
        modem_ctrl_reg <= {2'h0, w_data_reg[5:0]};
      end
      if (sel_pm) begin
        pin_mode_reg <= w_data_reg;
      end
      if (sel_im) begin
        if_mode_reg <= w_data_reg;
      end
      if (sel_txf) begin
        tx_flags_reg <= {5'h00, w_data_reg[2:0]};
      end
    end
  end

  // output pins carry the complement of the control bits
  always_ff @(posedge CORE_CLK) begin
    if (blk_rst) begin
      DTR_N <= 1'b1;
      RTS_N <= 1'b1;
      GP_OUTPUT_ZERO_N <= 1'b1;
      GP_OUTPUT_ONE_N <= 1'b1;
      GP_OUTPUT_TWO_N <= 1'b1;
      DTR_OE <= 1'b0;
      RTS_OE <= 1'b0;
      GP_OUTPUT_ZERO_OE <= 1'b0;
      GP_OUTPUT_ONE_OE <= 1'b0;
      GP_OUTPUT_TWO_OE <= 1'b0;
      LOOPBACK_EN <= 1'b0;
      LOOPBACK_KIND <= 2'h0;
    end else begin
      DTR_N <= !modem_ctrl_reg[MC_DTR];
      RTS_N <= !modem_ctrl_reg[MC_RTS];
      GP_OUTPUT_ZERO_N <= !modem_ctrl_reg[MC_GP_OUTPUT_ZERO];
      GP_OUTPUT_ONE_N <= !modem_ctrl_reg[MC_GP_OUTPUT_ONE];
      GP_OUTPUT_TWO_N <= !modem_ctrl_reg[MC_GP_OUTPUT_TWO];
      DTR_OE <= pin_mode_reg[PM_DTR_GP];
      RTS_OE <= pin_mode_reg[PM_RTS_GP];
      GP_OUTPUT_ZERO_OE <= pin_mode_reg[PM_GP_OUTPUT_ZERO_GP];
      GP_OUTPUT_ONE_OE <= pin_mode_reg[PM_GP_OUTPUT_ONE_GP];
      GP_OUTPUT_TWO_OE <= pin_mode_reg[PM_GP_OUTPUT_TWO_GP];
      LOOPBACK_EN <= modem_ctrl_reg[MC_LOOP];
      LOOPBACK_KIND <= if_mode_reg[1:0];
    end
  end

  // transmit push: byte and flags enter the queue as one character
  always_ff @(posedge CORE_CLK) begin
    if (blk_rst) begin
      TXQ_PUSH <= 1'b0;
      TXQ_DATA <= 8'h00;
      TXQ_FLAGS <= 3'h0;
    end else begin
      TXQ_PUSH <= sel_txb;
      if (sel_txb) begin
        TXQ_DATA <= w_data_reg;
        TXQ_FLAGS <= {tx_flags_reg[TF_MARKER], tx_flags_reg[TF_PARITY],
                      tx_flags_reg[TF_NINTH]};
      end
    end
  end

  // receive holder: one pop per empty holder; pop pulse blocks a double
  always_ff @(posedge CORE_CLK) begin
    if (blk_rst) begin
      rx_full_reg <= 1'b0;
      rx_data_reg <= 8'h00;
      rx_flags_reg <= 8'h00;
      RXQ_POP <= 1'b0;
    end else begin
      RXQ_POP <= 1'b0;
      if (cmd_rxq_flush) begin
        rx_full_reg <= 1'b0;
        rx_data_reg <= 8'h00;
        rx_flags_reg <= 8'h00;
      end else if (rd_rxb && rx_full_reg) begin
        rx_full_reg <= 1'b0;
      end else if (!rx_full_reg && RXQ_VALID && !RXQ_POP) begin
        rx_full_reg <= 1'b1;
        rx_data_reg <= RXQ_DATA;
        rx_flags_reg <= RXQ_FLAGS;
        RXQ_POP <= 1'b1;
      end
    end
  end
endmodule // asc_cmd_status

// ==== dv/asc_cmd_status_properties.sv ====
// port checks for the command and status block
// bound into every asc_cmd_status; sees its ports only
`timescale 1ns/1ns
module asc_cmd_status_properties (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [asc_pkg::DATA_W-1:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_BVALID,
  input wire logic DEVICE_RESET,
  input wire logic INT_OUT,
  input wire logic IRQ_PENDING,
  input wire logic TIMER_A_TC,
  input wire logic TIMER_IRQ_REQ,
  input wire logic TXQ_PUSH,
  input wire logic TIMER_A_START,
  input wire logic TX_QUEUE_FLUSH,
  input wire logic RXQ_POP,
  input wire logic RXQ_VALID,
  input wire logic RX_STATUS_CLEAR
);
  import asc_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  chk_rdata_upper_zero: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0) else $error("rdata high");
  chk_soft_reset_len: assert property (
    $rose(DEVICE_RESET) |-> DEVICE_RESET[*4] ##1 !DEVICE_RESET)
    else $error("soft reset length");
  // a fall while the cause stood can only be an acknowledge or a soft reset
  chk_ack_two_low: assert property (
    $fell(INT_OUT) && $past(IRQ_PENDING) |=> !INT_OUT)
    else $error("ack hold short");
  chk_timer_irq_set: assert property (
    TIMER_A_TC && !DEVICE_RESET |-> ##[1:2] TIMER_IRQ_REQ)
    else $error("timer irq missing");
  chk_push_at_resp: assert property (
    TXQ_PUSH |-> $rose(S_AXI_BVALID)) else $error("push off response");
  chk_cmd_self_clear: assert property (
    TIMER_A_START || TX_QUEUE_FLUSH |=> !TIMER_A_START && !TX_QUEUE_FLUSH)
    else $error("command stuck");
  chk_clear_at_resp: assert property (
    RX_STATUS_CLEAR |-> $rose(S_AXI_BVALID)) else $error("clear off write");
  chk_pop_needs_head: assert property (
    RXQ_POP |-> $past(RXQ_VALID)) else $error("pop of empty queue");
endmodule // asc_cmd_status_properties
bind asc_cmd_status asc_cmd_status_properties chk (.*);

// ==== dv/asc_rxq_model.sv ====
// behavioural receive queue in front of the rx holder
// assumes pops are one-cycle pulses on CORE_CLK
`timescale 1ns/1ns
module asc_rxq_model (
  input wire logic CORE_CLK,
  input wire logic RXQ_POP,
  output logic RXQ_VALID = 1'b0,
  output logic [7:0] RXQ_DATA = 8'hFF,
  output logic [7:0] RXQ_FLAGS = 8'hFF
);
  logic [15:0] q[$];
  logic [15:0] last = 16'h0000;
  task automatic load(input logic [15:0] x);
    q.push_back(x);
  endtask
  // empty head shows the inverse of the last entry, never a stale copy
  always @(posedge CORE_CLK) begin
    if (RXQ_POP && q.size() != 0)
      last = q.pop_front();
    RXQ_VALID <= q.size() != 0;
    {RXQ_FLAGS, RXQ_DATA} <= (q.size() != 0) ? q[0] : ~last;
  end
endmodule // asc_rxq_model

// ==== dv/asc_cmd_status_bench.sv ====
// self-checking bench: axi4-lite master, modem pins, timers, rx queue
// assumes the bind in the properties file and the rx queue model
`timescale 1ns/1ns
module asc_cmd_status_bench;
  import asc_pkg::*;
  logic CORE_CLK = 0, RST_B = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0;
  logic S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0, DCD_N = 1;
  logic RI_N = 1, DSR_N = 1, CTS_N = 1, IRQ_PENDING = 0, TXQ_READY = 1;
  logic TIMER_A_IS_BAUD = 0, TIMER_B_IS_BAUD = 0, TIMER_A_TC = 0;
  logic TIMER_B_TC = 0;
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, RXQ_DATA, RXQ_FLAGS;
  logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, GP_OUTPUT_ZERO_N;
  logic S_AXI_RVALID, DTR_N, DTR_OE, RTS_N, RTS_OE, GP_OUTPUT_ZERO_OE, GP_OUTPUT_ONE_N;
  logic GP_OUTPUT_ONE_OE, GP_OUTPUT_TWO_N, GP_OUTPUT_TWO_OE, LOOPBACK_EN, INT_OUT, MODEM_IRQ_REQ;
  logic TIMER_IRQ_REQ, DEVICE_RESET, POWER_DOWN, RX_STATUS_CLEAR;
  logic TX_ENABLE, TX_ENGINE_FLUSH, TX_QUEUE_FLUSH, RX_ENABLE, RXQ_POP;
  logic RX_ENGINE_FLUSH, RX_QUEUE_FLUSH, RX_QUEUE_WRITE_EN, TIMER_A_GATE;
  logic TIMER_B_GATE, TIMER_A_START, TIMER_B_START, TXQ_PUSH, RXQ_VALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, LOOPBACK_KIND, r;
  logic [2:0] TXQ_FLAGS;
  logic [7:0] TXQ_DATA;
  logic [31:0] d;
  logic [15:0] e;
  logic [10:0] txq[$];
  logic [15:0] rxq[$];
  int failures = 0, n_tests = 0, cyc = 0, seed = 94;
  // rows: {address, command byte, expected tx_en rx_en wr_en pdown}
  logic [19:0] tb[11] = '{20'h0804A, 20'h08082, 20'h0801A, 20'h0802A,
    20'h0C01E, 20'h0C02A, 20'h0C108, 20'h0C20A, 20'h0C108, 20'h0C04E,
    20'h0408F};
  asc_cmd_status dut (.*);
  asc_rxq_model fm (.*);
  always #25 CORE_CLK = ~CORE_CLK;
  task automatic stop_test;
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic ck(input string n, input logic [31:0] x, s);
    n_tests++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  // bready is offered with the request; the response follows both
  task automatic wr(input logic [7:0] a, d8);
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d8};
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    do begin
      @(posedge CORE_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
    end while (S_AXI_AWVALID || S_AXI_WVALID || !S_AXI_BVALID);
    S_AXI_BREADY <= 0;
  endtask
  task automatic rdck(input logic [7:0] a, input logic [31:0] x,
      input logic [1:0] xr);
    @(posedge CORE_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY <= 1;
    do begin
      @(posedge CORE_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
    end while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 0;
    ck("rdata", x, d);
    ck("rresp", {30'h0, xr}, {30'h0, r});
  endtask
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (TXQ_PUSH === 1'b1)
      ck("txq", {21'h0, txq.pop_front()}, {TXQ_FLAGS, TXQ_DATA});
    if (cyc == 8000) begin
      failures++;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(posedge CORE_CLK);
    RST_B <= 1;
    rdck(OFF_PIN_MODE, {24'h0, PIN_MODE_RST}, RESP_OKAY);
    rdck(OFF_DEVICE_CMD, 0, RESP_OKAY);
    rdck(8'h3C, 0, RESP_SLVERR);
    rdck(OFF_MODEM_STATUS, 0, RESP_OKAY);
    RI_N <= 0;
    CTS_N <= 0;
    repeat (3) @(posedge CORE_CLK);
    ck("mirq", 1, MODEM_IRQ_REQ);
    rdck(OFF_MODEM_STATUS, 32'h55, RESP_OKAY);
    rdck(OFF_MODEM_STATUS, 32'h50, RESP_OKAY);
    RI_N <= 1;
    DSR_N <= 0;
    repeat (3) @(posedge CORE_CLK);
    ck("mirq", 1, MODEM_IRQ_REQ);
    rdck(OFF_MODEM_STATUS, 32'h32, RESP_OKAY);
    repeat (4) begin
      e = 16'($random(seed));
      txq.push_back(e[10:0]);
      wr(OFF_TX_FLAGS, {5'h0, e[10:8]});
      wr(OFF_TX_BYTE, e[7:0]);
      e = 16'($random(seed));
      rxq.push_back(e);
      fm.load(e);
    end
    repeat (4) begin
      e = rxq.pop_front();
      repeat (4) @(posedge CORE_CLK);
      rdck(OFF_RX_FLAGS, {24'h0, e[15:8]}, RESP_OKAY);
      rdck(OFF_RX_BYTE, {24'h0, e[7:0]}, RESP_OKAY);
    end
    wr(OFF_IF_MODE, 8'h02);
    wr(OFF_MODEM_CTRL, 8'h13);
    repeat (2) @(posedge CORE_CLK);
    ck("pins", 32'h3A, {DTR_N, RTS_N, GP_OUTPUT_ONE_N, DTR_OE, LOOPBACK_EN, 1'b0,
      LOOPBACK_KIND});
    wr(OFF_DEVICE_CMD, 8'h01);
    repeat (8) @(posedge CORE_CLK);
    rdck(OFF_MODEM_CTRL, 0, RESP_OKAY);
    wr(OFF_TIMER_CMD, 8'h0C);
    rdck(OFF_TIMER_STATUS, 32'h0C, RESP_OKAY);
    ck("gates", 3, {TIMER_B_GATE, TIMER_A_GATE});
    wr(OFF_TIMER_CMD, 8'h0D);
    TIMER_A_TC <= 1;
    @(posedge CORE_CLK);
    TIMER_A_TC <= 0;
    repeat (3) @(posedge CORE_CLK);
    ck("tirq", 1, TIMER_IRQ_REQ);
    rdck(OFF_TIMER_STATUS, 32'h0D, RESP_OKAY);
    wr(OFF_DEVICE_CMD, 8'h04);
    rdck(OFF_TIMER_STATUS, 32'h0C, RESP_OKAY);
    IRQ_PENDING <= 1;
    repeat (3) @(posedge CORE_CLK);
    ck("int", 1, INT_OUT);
    wr(OFF_DEVICE_CMD, 8'h02);
    ck("int", 0, INT_OUT);
    @(posedge CORE_CLK);
    ck("int", 0, INT_OUT);
    @(posedge CORE_CLK);
    ck("int", 1, INT_OUT);
    foreach (tb[i]) begin
      wr(tb[i][19:12], tb[i][11:4]);
      repeat (2) @(posedge CORE_CLK);
      ck("state", tb[i][3:0], {TX_ENABLE, RX_ENABLE, RX_QUEUE_WRITE_EN,
        POWER_DOWN});
    end
    stop_test;
  end
endmodule // asc_cmd_status_bench
